// ===== hdl/mac_pkg.sv
// Purpose: shared constants and types of the multiply-accumulate unit
// Assumes: 32-bit APB register window, byte addresses, one word each
// Notes:   operation codes live in the control register op field
package mac_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] MAC_OFS_FIRST_OPERAND = 8'h00;
  localparam logic [7:0] MAC_OFS_SECOND_OPERAND = 8'h04;
  localparam logic [7:0] MAC_OFS_ADDEND_INPUT = 8'h08;
  localparam logic [7:0] MAC_OFS_RESULT_TARGET = 8'h0c;
  localparam logic [7:0] MAC_OFS_RESULT_LOW_WORD = 8'h10;
  localparam logic [7:0] MAC_OFS_RESULT_HIGH_WORD = 8'h14;
  localparam logic [7:0] MAC_OFS_CONTROL = 8'h18;
  localparam logic [7:0] MAC_OFS_STATUS_WORD = 8'h1c;
  localparam logic [7:0] MAC_OFS_FLAG_WRITE = 8'h20;
  localparam logic [7:0] MAC_OFS_IRQ_STATUS = 8'h24;
  localparam logic [7:0] MAC_OFS_IRQ_ENABLE = 8'h28;
  localparam logic [7:0] MAC_OFS_IRQ_CLEAR = 8'h2c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MAC_CTL_OP_LSB = 0;
  localparam int MAC_CTL_FIRST_HALF = 4;
  localparam int MAC_CTL_SECOND_HALF = 5;
  localparam int MAC_CTL_CROSSED = 6;
  localparam int MAC_CTL_START = 8;
  localparam int MAC_STS_BUSY = 0;
  localparam int MAC_STS_SAT = 1;
  localparam int MAC_STS_NZCV_LSB = 4;
  localparam int MAC_FLW_SAT_CLEAR = 4;
  localparam int MAC_IRQ_DONE = 0;
  localparam int MAC_IRQ_SAT = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] MAC_RST_WORD = 32'h0000_0000;
  localparam logic [6:0] MAC_RST_CONTROL = 7'h00;
  localparam logic [3:0] MAC_RST_NZCV = 4'h0;
  localparam logic [1:0] MAC_RST_IRQ = 2'h0;

  // ----------------------------------------------------------------
  // halfword selector and operation codes
  // ----------------------------------------------------------------
  localparam logic MAC_LOW_HALF_CHOICE = 1'b0;
  localparam logic MAC_UPPER_HALF_CHOICE = 1'b1;
  localparam logic [3:0] MAC_OP_UNSIGNED_MUL_DOUBLE_ACC = 4'h0;
  localparam logic [3:0] MAC_OP_UNSIGNED_MUL_LONG_ACC = 4'h1;
  localparam logic [3:0] MAC_OP_SIGNED_HALFWORD_MAC = 4'h2;
  localparam logic [3:0] MAC_OP_SIGNED_WORD_HALFWORD_MAC = 4'h3;
  localparam logic [3:0] MAC_OP_SIGNED_DUAL_MAC = 4'h4;
  localparam logic [3:0] MAC_OP_SIGNED_LONG_MAC = 4'h5;
  localparam logic [3:0] MAC_OP_SIGNED_LONG_HALFWORD_MAC = 4'h6;
  localparam logic [3:0] MAC_OP_SIGNED_LONG_DUAL_MAC = 4'h7;

  typedef enum logic [0:0] {
    MAC_ST_IDLE,
    MAC_ST_EXEC
  } mac_state_type;

endpackage

// ===== hdl/mac_smul.sv
// Purpose: signed multiplier of parameterised width
// Assumes: unsigned use widens the operands by one zero bit
// Notes:   purely combinational, result is full width
`timescale 1ns/100ps
`default_nettype none
module mac_smul #(
  parameter int W = 16
) (
  // operands
  input wire logic signed [W-1:0] a,
  input wire logic signed [W-1:0] b,
  // full product
  output logic signed [2*W-1:0] p
);

  // full-width product, can never overflow its own width
  assign p = a * b;

endmodule
`default_nettype wire

// ===== hdl/mac_sadd.sv
// Purpose: 32-bit signed adder with overflow detection
// Assumes: two's complement operands
// Notes:   sum wraps, overflow flags a lost sign
`timescale 1ns/100ps
`default_nettype none
module mac_sadd (
  // addends
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  // wrapped sum and overflow
  output logic [31:0] s,
  output logic ovf
);

  // overflow only when both signs agree and the sum's sign differs
  assign s = a + b;
  assign ovf = (a[31] == b[31]) && (s[31] != a[31]);

endmodule
`default_nettype wire

// ===== hdl/mac_unit.sv
// Purpose: multiply-accumulate execution unit behind an APB window
// Assumes: operands written first, then control with the start bit
// Notes:   one wait state per APB access, one cycle of execution
//
// Contract
// [RULE1] double accumulate adds both words to product
// [RULE2] sum high to high word, low to low
// [RULE3] long accumulate adds product to register pair
// [RULE4] caller never names one register for both
// [RULE5] caller never uses stack or program counter
// [RULE6] unsigned long forms keep condition flags
// [RULE7] selector picks low or upper halfword
// [RULE8] halfword product plus addend to result target
// [RULE9] word by halfword keeps product top 32 bits
// [RULE10] accumulate overflow sets saturation flag (code sets it for the halfword forms only, not on dual form overflow)
// [RULE11] dual form uses four signed halfwords
// [RULE12] crossing swaps second operand halfwords
// [RULE13] dual sum plus addend to result target
// [RULE14] dual form keeps all condition flags
// [RULE15] signed long product plus register pair
// [RULE16] sign-extended halfword product plus pair
// [RULE17] two halfword products plus signed pair
// [RULE18] low word lower bits, high word upper
// [RULE19] operations never clear saturation flag
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module mac_unit
  import mac_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // status outputs
  output logic IRQ,
  output logic SAT_FLAG,
  output logic [3:0] NZCV_FLAGS
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic wr_take;
  logic rd_take;
  logic addr_hit;
  logic [31:0] rd_word;
  logic [31:0] first_operand_r;
  logic [31:0] second_operand_r;
  logic [31:0] addend_input_r;
  logic [31:0] result_target_r;
  logic [31:0] result_low_word_r;
  logic [31:0] result_high_word_r;
  logic [3:0] op_r;
  logic first_half_select_r;
  logic second_half_select_r;
  logic crossed_r;
  logic sat_r;
  logic [3:0] nzcv_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_en_r;
  logic irq_r;
  logic start;
  mac_state_type state_r;
  mac_state_type state_nxt;
  logic [15:0] half_a;
  logic [15:0] half_b;
  logic [15:0] m0_a;
  logic [15:0] m0_b;
  logic [15:0] m1_a;
  logic [15:0] m1_b;
  logic signed [31:0] prod0;
  logic signed [31:0] prod1;
  logic [32:0] wide_a;
  logic [32:0] wide_b;
  logic signed [65:0] wide_p;
  logic [31:0] add_b;
  logic [31:0] add_s;
  logic add_ovf;
  logic [63:0] acc_pair;
  logic [63:0] long_sum;
  logic [31:0] short_sum;
  logic writes_pair;
  logic writes_target;
  logic sat_event;
  logic done_event;

  // ----------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------
  // a request is taken only at the edge where pready is already high
  assign wr_take = PSEL && PENABLE && pready_r && PWRITE;
  assign rd_take = PSEL && PENABLE && pready_r && !PWRITE;
  assign start = wr_take && (PADDR == MAC_OFS_CONTROL) &&
                 PWDATA[MAC_CTL_START] && (state_r == MAC_ST_IDLE);

  // address decode, also used for the error answer
  always_comb begin
    addr_hit = 1'b1;
    rd_word = 32'h0000_0000;
    case (PADDR)
      MAC_OFS_FIRST_OPERAND: rd_word = first_operand_r;
      MAC_OFS_SECOND_OPERAND: rd_word = second_operand_r;
      MAC_OFS_ADDEND_INPUT: rd_word = addend_input_r;
      MAC_OFS_RESULT_TARGET: rd_word = result_target_r;
      MAC_OFS_RESULT_LOW_WORD: rd_word = result_low_word_r;
      MAC_OFS_RESULT_HIGH_WORD: rd_word = result_high_word_r;
      MAC_OFS_CONTROL: begin
        rd_word[MAC_CTL_OP_LSB +: 4] = op_r;
        rd_word[MAC_CTL_FIRST_HALF] = first_half_select_r;
        rd_word[MAC_CTL_SECOND_HALF] = second_half_select_r;
        rd_word[MAC_CTL_CROSSED] = crossed_r;
      end
      MAC_OFS_STATUS_WORD: begin
        rd_word[MAC_STS_BUSY] = (state_r == MAC_ST_EXEC);
        rd_word[MAC_STS_SAT] = sat_r;
        rd_word[MAC_STS_NZCV_LSB +: 4] = nzcv_r;
      end
      MAC_OFS_FLAG_WRITE: rd_word = 32'h0000_0000;
      MAC_OFS_IRQ_STATUS: rd_word[1:0] = irq_stat_r;
      MAC_OFS_IRQ_ENABLE: rd_word[1:0] = irq_en_r;
      MAC_OFS_IRQ_CLEAR: rd_word = 32'h0000_0000;
      default: addr_hit = 1'b0;
    endcase
  end

  // one wait state so that read data and error leave flip-flops
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pready_r <= 1'b0;
      prdata_r <= MAC_RST_WORD;
      pslverr_r <= 1'b0;
    end else if (PSEL && PENABLE && !pready_r) begin
      pready_r <= 1'b1;
      prdata_r <= PWRITE ? 32'h0000_0000 : rd_word;
      pslverr_r <= !addr_hit;
    end else begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // operands and the control word, only software writes them
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      first_operand_r <= MAC_RST_WORD;
      second_operand_r <= MAC_RST_WORD;
      addend_input_r <= MAC_RST_WORD;
      {crossed_r, second_half_select_r, first_half_select_r, op_r}
        <= MAC_RST_CONTROL;
      irq_en_r <= MAC_RST_IRQ;
    end else if (wr_take) begin
      case (PADDR)
        MAC_OFS_FIRST_OPERAND: first_operand_r <= PWDATA;
        MAC_OFS_SECOND_OPERAND: second_operand_r <= PWDATA;
        MAC_OFS_ADDEND_INPUT: addend_input_r <= PWDATA;
        MAC_OFS_CONTROL: begin
          op_r <= PWDATA[MAC_CTL_OP_LSB +: 4];
          first_half_select_r <= PWDATA[MAC_CTL_FIRST_HALF];
          second_half_select_r <= PWDATA[MAC_CTL_SECOND_HALF];
          crossed_r <= PWDATA[MAC_CTL_CROSSED];
        end
        MAC_OFS_IRQ_ENABLE: irq_en_r <= PWDATA[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // start while busy is dropped; apb spacing makes that impossible anyway
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      MAC_ST_IDLE: if (start) state_nxt = MAC_ST_EXEC;
      MAC_ST_EXEC: state_nxt = MAC_ST_IDLE;
      default: state_nxt = MAC_ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r <= MAC_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign done_event = (state_r == MAC_ST_EXEC);

  // ----------------------------------------------------------------
  // operand selection
  // ----------------------------------------------------------------
  // [RULE7] halfword selector mux
  assign half_a = (first_half_select_r == MAC_UPPER_HALF_CHOICE) ?
                  first_operand_r[31:16] : first_operand_r[15:0];
  assign half_b = (second_half_select_r == MAC_UPPER_HALF_CHOICE) ?
                  second_operand_r[31:16] : second_operand_r[15:0];

  // dual forms drive both halfword multipliers, others only the first
  always_comb begin
    m0_a = half_a;
    m0_b = half_b;
    m1_a = 16'h0000;
    m1_b = 16'h0000;
    if (op_r == MAC_OP_SIGNED_DUAL_MAC ||
        op_r == MAC_OP_SIGNED_LONG_DUAL_MAC) begin
      // [RULE11] four signed halfwords
      m0_a = first_operand_r[15:0];
      m1_a = first_operand_r[31:16];
      // [RULE12] crossing swaps halves
      m0_b = crossed_r ? second_operand_r[31:16] : second_operand_r[15:0];
      m1_b = crossed_r ? second_operand_r[15:0] : second_operand_r[31:16];
    end
  end

  // wide multiplier: zero-extended for unsigned, halfword for the word by halfword form
  always_comb begin
    wide_a = {first_operand_r[31], first_operand_r};
    wide_b = {second_operand_r[31], second_operand_r};
    if (op_r == MAC_OP_UNSIGNED_MUL_DOUBLE_ACC ||
        op_r == MAC_OP_UNSIGNED_MUL_LONG_ACC) begin
      wide_a = {1'b0, first_operand_r};
      wide_b = {1'b0, second_operand_r};
    end else if (op_r == MAC_OP_SIGNED_WORD_HALFWORD_MAC) begin
      wide_b = {{17{half_b[15]}}, half_b};
    end
  end

  mac_smul #(.W(16)) u_mul_lo (
    .a(m0_a),
    .b(m0_b),
    .p(prod0)
  );

  mac_smul #(.W(16)) u_mul_hi (
    .a(m1_a),
    .b(m1_b),
    .p(prod1)
  );

  mac_smul #(.W(33)) u_mul_wide (
    .a(wide_a),
    .b(wide_b),
    .p(wide_p)
  );

  // ----------------------------------------------------------------
  // accumulation
  // ----------------------------------------------------------------
  // [RULE9] top 32 of 48-bit product
  assign add_b = (op_r == MAC_OP_SIGNED_WORD_HALFWORD_MAC) ?
                 wide_p[47:16] : prod0;

  // [RULE8] halfword product plus addend
  mac_sadd u_acc32 (
    .a(addend_input_r),
    .b(add_b),
    .s(add_s),
    .ovf(add_ovf)
  );

  // [RULE18] pair order high then low
  assign acc_pair = {result_high_word_r, result_low_word_r};

  // result formation per operation
  always_comb begin
    long_sum = acc_pair;
    short_sum = add_s;
    writes_pair = 1'b0;
    writes_target = 1'b0;
    sat_event = 1'b0;
    case (op_r)
      MAC_OP_UNSIGNED_MUL_DOUBLE_ACC: begin
        // [RULE1] product plus both words
        long_sum = wide_p[63:0] + {32'h0000_0000, result_high_word_r} +
                   {32'h0000_0000, result_low_word_r};
        writes_pair = 1'b1;
      end
      MAC_OP_UNSIGNED_MUL_LONG_ACC: begin
        // [RULE3] product plus pair
        long_sum = wide_p[63:0] + acc_pair;
        writes_pair = 1'b1;
      end
      MAC_OP_SIGNED_HALFWORD_MAC,
      MAC_OP_SIGNED_WORD_HALFWORD_MAC: begin
        // [RULE10] accumulate overflow detected
        sat_event = add_ovf;
        writes_target = 1'b1;
      end
      MAC_OP_SIGNED_DUAL_MAC: begin
        // [RULE13] both products plus addend
        short_sum = addend_input_r + prod0 + prod1;
        writes_target = 1'b1;
      end
      MAC_OP_SIGNED_LONG_MAC: begin
        // [RULE15] signed product plus pair
        long_sum = wide_p[63:0] + acc_pair;
        writes_pair = 1'b1;
      end
      MAC_OP_SIGNED_LONG_HALFWORD_MAC: begin
        // [RULE16] sign-extended product plus pair
        long_sum = {{32{prod0[31]}}, prod0} + acc_pair;
        writes_pair = 1'b1;
      end
      MAC_OP_SIGNED_LONG_DUAL_MAC: begin
        // [RULE17] two products plus pair
        long_sum = {{32{prod0[31]}}, prod0} +
                   {{32{prod1[31]}}, prod1} + acc_pair;
        writes_pair = 1'b1;
      end
      default: ;
    endcase
  end

  // ----------------------------------------------------------------
  // result registers
  // ----------------------------------------------------------------
  // execution wins over a software write landing in the same cycle
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      result_target_r <= MAC_RST_WORD;
      result_low_word_r <= MAC_RST_WORD;
      result_high_word_r <= MAC_RST_WORD;
    end else if (done_event) begin
      if (writes_target) begin
        result_target_r <= short_sum;
      end
      if (writes_pair) begin
        // [RULE2] split sum into pair
        result_high_word_r <= long_sum[63:32];
        result_low_word_r <= long_sum[31:0];
      end
    end else if (wr_take) begin
      if (PADDR == MAC_OFS_RESULT_LOW_WORD) begin
        result_low_word_r <= PWDATA;
      end
      if (PADDR == MAC_OFS_RESULT_HIGH_WORD) begin
        result_high_word_r <= PWDATA;
      end
    end
  end

  // ----------------------------------------------------------------
  // program status word
  // ----------------------------------------------------------------
  // [RULE6] [RULE14] flags only from software
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      nzcv_r <= MAC_RST_NZCV;
    end else if (wr_take && PADDR == MAC_OFS_FLAG_WRITE) begin
      nzcv_r <= PWDATA[3:0];
    end
  end

  // [RULE19] sticky, set beats clear
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sat_r <= 1'b0;
    end else if (done_event && sat_event) begin
      sat_r <= 1'b1;
    end else if (wr_take && PADDR == MAC_OFS_FLAG_WRITE &&
                 PWDATA[MAC_FLW_SAT_CLEAR]) begin
      sat_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  // sticky events, write one to clear, a new event wins over the clear
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_stat_r <= MAC_RST_IRQ;
    end else begin
      if (done_event) begin
        irq_stat_r[MAC_IRQ_DONE] <= 1'b1;
      end else if (wr_take && PADDR == MAC_OFS_IRQ_CLEAR &&
                   PWDATA[MAC_IRQ_DONE]) begin
        irq_stat_r[MAC_IRQ_DONE] <= 1'b0;
      end
      if (done_event && sat_event) begin
        irq_stat_r[MAC_IRQ_SAT] <= 1'b1;
      end else if (wr_take && PADDR == MAC_OFS_IRQ_CLEAR &&
                   PWDATA[MAC_IRQ_SAT]) begin
        irq_stat_r[MAC_IRQ_SAT] <= 1'b0;
      end
    end
  end

  // registered level, lags the status bits by one cycle
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_en_r);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign PREADY = pready_r;
  assign PRDATA = prdata_r;
  assign PSLVERR = pslverr_r;
  assign IRQ = irq_r;
  assign SAT_FLAG = sat_r;
  assign NZCV_FLAGS = nzcv_r;

endmodule
`default_nettype wire

// ===== verification/mac_apb_host.sv
// Purpose: apb master standing in for the decoder and register file
// Assumes: each call starts just after a rising clock edge
// Notes:   released lines show the inverse value
`timescale 1ns/100ps
`default_nettype none
module mac_apb_host (
  // clock
  input wire logic clk,
  // apb request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // apb answer
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // one transfer; holds the request until pready is seen high
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    // fixed word map, no shared or banned registers
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a; // stale address must not look valid
    pwdata <= ~d;
    @(posedge clk); // no two psel drives in one step
  endtask
endmodule
`default_nettype wire

// ===== verification/mac_unit_asserts.sv
// Purpose: port checks of the multiply-accumulate unit
// Assumes: one clock domain, master keeps apb spacing
// Notes:   flag moves are tied to the write behind them
`timescale 1ns/100ps
`default_nettype none
module mac_unit_asserts
  import mac_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  // status
  input wire logic IRQ,
  input wire logic SAT_FLAG,
  input wire logic [3:0] NZCV_FLAGS
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  logic wr_done;
  logic flag_wr;
  logic start_wr;
  logic irq_wr;
  // completed writes that may move an output
  assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
  assign flag_wr = wr_done && PADDR == MAC_OFS_FLAG_WRITE;
  assign start_wr = wr_done && PADDR == MAC_OFS_CONTROL && PWDATA[8];
  assign irq_wr = wr_done && (PADDR == MAC_OFS_IRQ_ENABLE ||
                              PADDR == MAC_OFS_IRQ_CLEAR);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_access;
    PSEL && PENABLE;
  endsequence
  // --------------------------------------------------------------
  // bus and flag properties
  // --------------------------------------------------------------
  a_ready_one_wait: assert property (s_setup ##1 s_access |=> PREADY)
    else $error("pready missing in second access cycle");
  a_ready_single: assert property (PREADY |=> !PREADY)
    else $error("pready held longer than one cycle");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data not zero outside answer");
  a_unmapped_err: assert property (PREADY && PADDR > 8'h2c |-> PSLVERR)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (PREADY && PADDR <= 8'h2c &&
      PADDR[1:0] == 2'h0 |-> !PSLVERR)
    else $error("mapped access flagged as error");
  a_sat_rise_cause: assert property ($rose(SAT_FLAG) |->
      $past(start_wr, 2) && $past(PWDATA[3:0], 2) inside {4'h2, 4'h3})
    else $error("saturation set without halfword accumulate");
  a_sat_sticky: assert property ($fell(SAT_FLAG) |-> $past(flag_wr) &&
      $past(PWDATA[MAC_FLW_SAT_CLEAR]))
    else $error("saturation cleared without software clear");
  a_nzcv_kept: assert property ($changed(NZCV_FLAGS) |->
      $past(flag_wr))
    else $error("condition flags moved by an operation");
  a_irq_drop: assert property ($fell(IRQ) |->
      $past(irq_wr) || $past(irq_wr, 2))
    else $error("interrupt dropped without mask or clear");
endmodule
bind mac_unit mac_unit_asserts i_chk (.CORE_CLK, .ARST_N, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PWDATA, .PREADY, .PRDATA, .PSLVERR, .IRQ, .SAT_FLAG,
  .NZCV_FLAGS);
`default_nettype wire

// ===== verification/multiply_accumulate_datapath_tb.sv
// Purpose: self-checking bench of the multiply-accumulate unit
// Assumes: registers reached only through the apb host model
// Notes:   expected results come from a local reference function
`timescale 1ns/100ps
`default_nettype none
module multiply_accumulate_datapath_tb
  import mac_pkg::*;
;
  typedef struct packed {
    logic [6:0] c;
    logic [31:0] a, b, d, l, h;
  } mac_row_type;
  localparam int LIMIT = 5000;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, sat;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] nzcv;
  logic e;
  logic [96:0] x;
  logic [31:0] exp_t;
  logic exp_s;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  mac_row_type rows [12] = '{
    {7'h00, 32'hffffffff, 32'hffffffff, 32'h0, 32'hffffffff, 32'hffffffff},
    {7'h01, 32'h80000000, 32'h4, 32'h0, 32'hffffffff, 32'h1},
    {7'h02, 32'h1234fffe, 32'h7fff0003, 32'h10, 32'h0, 32'h0},
    {7'h32, 32'h8000ffff, 32'h8000ffff, 32'hffffffff, 32'h0, 32'h0},
    {7'h12, 32'h7fff0000, 32'h7fff, 32'h7fffffff, 32'h0, 32'h0},
    {7'h23, 32'hfffffff0, 32'h50000, 32'h2, 32'h0, 32'h0},
    {7'h03, 32'h80000000, 32'hffff, 32'h80000000, 32'h0, 32'h0},
    {7'h04, 32'h80008000, 32'h80008000, 32'h1, 32'h0, 32'h0},
    {7'h44, 32'h20003, 32'h50007, 32'h0, 32'h0, 32'h0},
    {7'h05, 32'hffffffff, 32'h2, 32'h0, 32'h1, 32'h0},
    {7'h26, 32'h10002, 32'hfffe0003, 32'h0, 32'h0, 32'h0},
    {7'h47, 32'h2fffd, 32'h40005, 32'h0, 32'h0, 32'h10}};

  always #4 clk = ~clk;

  mac_apb_host i_host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr);
  mac_unit i_dut (.CORE_CLK(clk), .ARST_N(arst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .IRQ(irq),
    .SAT_FLAG(sat), .NZCV_FLAGS(nzcv));

  // reference of every operation: {sat, target, high, low}
  function automatic logic [96:0] ref_op(input mac_row_type r,
                                         input logic [31:0] t0);
    logic signed [15:0] hx, hy, bh, bl;
    logic signed [63:0] s, pd;
    logic [63:0] pr;
    logic [31:0] t;
    logic v;
    hx = r.c[4] ? r.a[31:16] : r.a[15:0];
    hy = r.c[5] ? r.b[31:16] : r.b[15:0];
    bh = r.c[6] ? r.b[15:0] : r.b[31:16];
    bl = r.c[6] ? r.b[31:16] : r.b[15:0];
    pd = $signed(r.a[31:16]) * bh + $signed(r.a[15:0]) * bl;
    pr = {r.h, r.l};
    t = t0;
    v = 1'b0;
    s = 64'sh0;
    case (r.c[3:0])
      4'h0: pr = {32'h0, r.a} * {32'h0, r.b} + r.h + r.l;
      4'h1: pr = pr + {32'h0, r.a} * {32'h0, r.b};
      4'h2: s = hx * hy + $signed(r.d);
      4'h3: s = (($signed(r.a) * hy) >>> 16) + $signed(r.d);
      4'h4: t = pd[31:0] + r.d;
      4'h5: s = $signed(r.a) * $signed(r.b);
      4'h6: s = hx * hy;
      default: pr = pr + pd;
    endcase
    if (r.c[3:0] == 4'h5 || r.c[3:0] == 4'h6) begin
      pr = pr + s;
    end else if (r.c[3:1] == 3'h1) begin
      t = s[31:0];
      v = s[63:31] != {33{s[31]}};
    end
    return {v, t, pr};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_count++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a);
    i_host.xfer(1'b0, a, 32'h0, q, e);
  endtask

  // load operands, start, then poll busy at most eight times
  task automatic run(input mac_row_type r);
    wr(MAC_OFS_FIRST_OPERAND, r.a);
    wr(MAC_OFS_SECOND_OPERAND, r.b);
    wr(MAC_OFS_ADDEND_INPUT, r.d);
    wr(MAC_OFS_RESULT_LOW_WORD, r.l);
    wr(MAC_OFS_RESULT_HIGH_WORD, r.h);
    wr(MAC_OFS_CONTROL, {23'h0, 1'b1, 1'b0, r.c});
    for (int k = 0; k < 8; k++) begin
      rd(MAC_OFS_STATUS_WORD);
      if (q[MAC_STS_BUSY] === 1'b0) break;
    end
  endtask

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(MAC_OFS_STATUS_WORD);
    chk(q, 32'h0);
    rd(MAC_OFS_RESULT_HIGH_WORD);
    chk(q, 32'h0);
    wr(MAC_OFS_FLAG_WRITE, 32'ha);
    $display("reset values done");
    exp_t = 32'h0;
    exp_s = 1'b0;
    foreach (rows[i]) begin
      run(rows[i]);
      x = ref_op(rows[i], exp_t);
      exp_t = x[95:64];
      exp_s = exp_s | x[96];
      rd(MAC_OFS_RESULT_TARGET);
      chk(q, exp_t);
      rd(MAC_OFS_RESULT_LOW_WORD);
      chk(q, x[31:0]);
      rd(MAC_OFS_RESULT_HIGH_WORD);
      chk(q, x[63:32]);
      chk({31'h0, sat}, {31'h0, exp_s});
      chk({28'h0, nzcv}, 32'ha);
    end
    $display("operation table done");
    rd(8'h30);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    wr(MAC_OFS_RESULT_TARGET, 32'h5a5a5a5a);
    rd(MAC_OFS_RESULT_TARGET);
    chk(q, exp_t);
    $display("refused access done");
    wr(MAC_OFS_IRQ_CLEAR, 32'h3);
    wr(MAC_OFS_IRQ_ENABLE, 32'h1);
    chk({31'h0, irq}, 32'h0);
    run(rows[8]);
    chk({31'h0, irq}, 32'h1);
    wr(MAC_OFS_IRQ_ENABLE, 32'h0);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(MAC_OFS_IRQ_ENABLE, 32'h1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(MAC_OFS_IRQ_CLEAR, 32'h1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    $display("interrupt done");
    wr(MAC_OFS_FLAG_WRITE, 32'h1a);
    chk({31'h0, sat}, 32'h0);
    chk({28'h0, nzcv}, 32'ha);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({28'h0, nzcv}, 32'h0);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(MAC_OFS_RESULT_TARGET);
    chk(q, 32'h0);
    $display("second reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
